// ==== pifb_pkg.sv ====
// pifb_pkg: constants and types for the peripheral interrupt flag bank.
// assumes a single clock domain and 32-bit AXI4-Lite register access.
package pifb_pkg;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam int ADDR_W = 6;
	localparam int NGRP = 6;
	localparam logic [5:0] CTRL_OFS = 6'h00;
	localparam logic [5:0] EN_BASE = 6'h04;
	localparam logic [5:0] FLAG_BASE = 6'h1C;
	localparam logic [5:0] MAP_END = 6'h34;

	// ----------------------------------------------------------------
	// group indices: comparator, serial, timer, logic/gate, capture, misc
	// ----------------------------------------------------------------
	localparam int G_COMP = 0;
	localparam int G_SERIAL = 1;
	localparam int G_TIMER = 2;
	localparam int G_LOGIC = 3;
	localparam int G_CAPT = 4;
	localparam int G_MISC = 5;

	// ----------------------------------------------------------------
	// bit positions
	// ----------------------------------------------------------------
	localparam int RX_BIT = 5;
	localparam int TX_BIT = 4;
	localparam int BCL_BIT = 1;
	localparam int SSP_BIT = 0;
	localparam int TMR2_BIT = 1;
	localparam int TMR1_BIT = 0;
	localparam int CLC_LSB = 4;
	localparam int GATE_BIT = 0;
	localparam int CCP2_BIT = 1;
	localparam int CCP1_BIT = 0;
	localparam int NVM_BIT = 5;
	localparam int NCO_BIT = 4;
	localparam int CWG_BIT = 0;
	localparam int COMP2_BIT = 1;
	localparam int GIE_BIT = 7;
	localparam int PERIPHERAL_INT_ENABLE_BIT = 6;
	localparam int EDGE_BIT = 0;

	// ----------------------------------------------------------------
	// implemented-bit masks and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] MASK_COMP2 = 8'h02;
	localparam logic [7:0] MASK_SERIAL = 8'h33;
	localparam logic [7:0] MASK_SERIAL_STICKY = 8'h03;
	localparam logic [7:0] MASK_TIMER = 8'h03;
	localparam logic [7:0] MASK_LOGIC = 8'hF1;
	localparam logic [7:0] MASK_CAPT = 8'h03;
	localparam logic [7:0] MASK_MISC = 8'h31;
	localparam logic [7:0] MASK_CTRL = 8'hC1;
	localparam logic [7:0] RST_VAL = 8'h00;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		PIFB_CCP_CAPTURE,
		PIFB_CCP_COMPARE,
		PIFB_CCP_PWM
	} pifb_ccp_mode_t;

	typedef struct packed {
		logic bus_collision;
		logic ssp_done;
		logic tmr2_match;
		logic tmr2_post_ovf;
		logic tmr2_post_1to1;
		logic tmr1_ovf;
		logic tmr1_gate_active;
		logic [3:0] clc_int;
		pifb_ccp_mode_t ccp2_mode;
		pifb_ccp_mode_t ccp1_mode;
		logic [1:0] ccp_capture;
		logic [1:0] ccp_match;
		logic [1:0] ccp_trail;
		logic nvm_done;
		logic nco_rollover;
		logic cwg_shutdown;
		logic comp2_int;
	} pifb_event_t;

	typedef struct packed {
		logic rx_not_empty;
		logic tx_has_space;
	} pifb_serial_t;

endpackage

// ==== pifb_flag_bank.sv ====
// pifb_flag_bank: peripheral interrupt request flags, enables and
// global control, reached over an AXI4-Lite slave.
// assumes peripheral event inputs are one-cycle pulses synchronous
// to aclk, and gate/shutdown/serial inputs are levels.
`timescale 1ns/1ps

// Overview of operation
// RULE_01: receive flag at bit 5 is read-only, high while receive buffer holds data.
// RULE_02: software empties receive buffer by reading data; writing the flag does nothing.
// RULE_03: transmit flag at bit 4 is read-only, high while transmit buffer has space.
// RULE_04: software never writes transmit data while the transmit flag is low.
// RULE_05: transmit flag clears only when the buffer is full, not on send complete.
// RULE_06: bus collision sets sticky flag at bit 1 until software clears it.
// RULE_07: serial port completion sets flag at bit 0; software clears it.
// RULE_08: period timer flag at bit 1 on postscaler overflow, or match at 1:1.
// RULE_09: wide timer overflow sets flag at bit 0 until software clears it.
// RULE_10: logic cells four to one set flags at bits 7 down to 4.
// RULE_11: timer gate going inactive sets flag at bit 0.
// RULE_12: capture units set bits 1 and 0 on capture, match or PWM trailing edge.
// RULE_13: memory operation completion sets flag at bit 5.
// RULE_14: oscillator accumulator rollover sets flag at bit 4.
// RULE_15: waveform generator entering shutdown sets flag at bit 0.
// RULE_16: unimplemented bits of enable, request and control registers read zero.
// RULE_17: every request flag resets to zero on any reset; bits 5 and 4 follow the serial buffer levels instead.
// RULE_18: comparator two bits exist only when the larger variant is selected.
// RULE_19: peripheral request asserts when any flag and its same-position enable are set.
module pifb_flag_bank #(
	parameter bit HAS_COMP2 = 1'b1 // larger package variant
) (
	input wire logic aclk, // 125 MHz clock
	input wire logic aresetn, // synchronous reset, active low
	input wire logic [5:0] s_axi_awaddr, // write address
	input wire logic [2:0] s_axi_awprot, // unused protection
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write byte strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [5:0] s_axi_araddr, // read address
	input wire logic [2:0] s_axi_arprot, // unused protection
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire pifb_pkg::pifb_event_t periph_ev, // peripheral events
	input wire pifb_pkg::pifb_serial_t serial_st, // serial buffer levels
	output logic periph_int_req, // any enabled flag set
	output logic irq // gated by global enables
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [7:0] en_r [pifb_pkg::NGRP];
	logic [7:0] en_nxt [pifb_pkg::NGRP];
	logic [7:0] flag_r [pifb_pkg::NGRP];
	logic [7:0] flag_nxt [pifb_pkg::NGRP];
	logic [7:0] ctrl_r;
	logic [7:0] ctrl_nxt;
	logic gate_prev_r;
	logic gate_prev_nxt;
	logic cwg_prev_r;
	logic cwg_prev_nxt;
	logic bvalid_r;
	logic bvalid_nxt;
	logic [1:0] bresp_r;
	logic [1:0] bresp_nxt;
	logic rvalid_r;
	logic rvalid_nxt;
	logic [1:0] rresp_r;
	logic [1:0] rresp_nxt;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic [7:0] mask [pifb_pkg::NGRP];
	logic [7:0] sticky_mask [pifb_pkg::NGRP];
	logic [7:0] set_vec [pifb_pkg::NGRP];
	logic [7:0] view [pifb_pkg::NGRP];
	logic wr_go;
	logic rd_go;
	logic [pifb_pkg::NGRP-1:0] hit;

	// ----------------------------------------------------------------
	// implemented-bit masks
	// ----------------------------------------------------------------
	always_comb begin
		mask[pifb_pkg::G_COMP] = HAS_COMP2 ? pifb_pkg::MASK_COMP2 : pifb_pkg::RST_VAL; // RULE_18
		mask[pifb_pkg::G_SERIAL] = pifb_pkg::MASK_SERIAL;
		mask[pifb_pkg::G_TIMER] = pifb_pkg::MASK_TIMER;
		mask[pifb_pkg::G_LOGIC] = pifb_pkg::MASK_LOGIC;
		mask[pifb_pkg::G_CAPT] = pifb_pkg::MASK_CAPT;
		mask[pifb_pkg::G_MISC] = pifb_pkg::MASK_MISC;
		sticky_mask = mask;
		sticky_mask[pifb_pkg::G_SERIAL] = pifb_pkg::MASK_SERIAL_STICKY; // RULE_01
	end

	// ----------------------------------------------------------------
	// hardware set conditions
	// ----------------------------------------------------------------
	always_comb begin
		for (int g = 0; g < pifb_pkg::NGRP; g++) begin
			set_vec[g] = pifb_pkg::RST_VAL;
		end
		set_vec[pifb_pkg::G_COMP][pifb_pkg::COMP2_BIT] = periph_ev.comp2_int;
		set_vec[pifb_pkg::G_SERIAL][pifb_pkg::BCL_BIT] = periph_ev.bus_collision; // RULE_06
		set_vec[pifb_pkg::G_SERIAL][pifb_pkg::SSP_BIT] = periph_ev.ssp_done; // RULE_07
		// at 1:1 the postscaler is bypassed, so the period match itself counts
		set_vec[pifb_pkg::G_TIMER][pifb_pkg::TMR2_BIT] = periph_ev.tmr2_post_1to1 ?
			periph_ev.tmr2_match : periph_ev.tmr2_post_ovf; // RULE_08
		set_vec[pifb_pkg::G_TIMER][pifb_pkg::TMR1_BIT] = periph_ev.tmr1_ovf; // RULE_09
		set_vec[pifb_pkg::G_LOGIC][pifb_pkg::CLC_LSB+:4] = periph_ev.clc_int; // RULE_10
		// gate falling from active to inactive ends the acquisition
		set_vec[pifb_pkg::G_LOGIC][pifb_pkg::GATE_BIT] = gate_prev_r & ~periph_ev.tmr1_gate_active; // RULE_11
		unique case (periph_ev.ccp1_mode)
			pifb_pkg::PIFB_CCP_CAPTURE: set_vec[pifb_pkg::G_CAPT][pifb_pkg::CCP1_BIT] = periph_ev.ccp_capture[0];
			pifb_pkg::PIFB_CCP_COMPARE: set_vec[pifb_pkg::G_CAPT][pifb_pkg::CCP1_BIT] = periph_ev.ccp_match[0];
			pifb_pkg::PIFB_CCP_PWM: set_vec[pifb_pkg::G_CAPT][pifb_pkg::CCP1_BIT] = periph_ev.ccp_trail[0]; // RULE_12
			default: set_vec[pifb_pkg::G_CAPT][pifb_pkg::CCP1_BIT] = 1'b0;
		endcase
		unique case (periph_ev.ccp2_mode)
			pifb_pkg::PIFB_CCP_CAPTURE: set_vec[pifb_pkg::G_CAPT][pifb_pkg::CCP2_BIT] = periph_ev.ccp_capture[1];
			pifb_pkg::PIFB_CCP_COMPARE: set_vec[pifb_pkg::G_CAPT][pifb_pkg::CCP2_BIT] = periph_ev.ccp_match[1];
			pifb_pkg::PIFB_CCP_PWM: set_vec[pifb_pkg::G_CAPT][pifb_pkg::CCP2_BIT] = periph_ev.ccp_trail[1]; // RULE_12
			default: set_vec[pifb_pkg::G_CAPT][pifb_pkg::CCP2_BIT] = 1'b0;
		endcase
		set_vec[pifb_pkg::G_MISC][pifb_pkg::NVM_BIT] = periph_ev.nvm_done; // RULE_13
		set_vec[pifb_pkg::G_MISC][pifb_pkg::NCO_BIT] = periph_ev.nco_rollover; // RULE_14
		// only the entry into shutdown sets the flag, not the level
		set_vec[pifb_pkg::G_MISC][pifb_pkg::CWG_BIT] = ~cwg_prev_r & periph_ev.cwg_shutdown; // RULE_15
	end

	// ----------------------------------------------------------------
	// software view of the flags, with live serial buffer levels
	// ----------------------------------------------------------------
	always_comb begin
		for (int g = 0; g < pifb_pkg::NGRP; g++) begin
			view[g] = flag_r[g] & mask[g]; // RULE_16
		end
		view[pifb_pkg::G_SERIAL][pifb_pkg::RX_BIT] = serial_st.rx_not_empty; // RULE_01
		// low only while the buffer is full; shifter-empty status is elsewhere
		view[pifb_pkg::G_SERIAL][pifb_pkg::TX_BIT] = serial_st.tx_has_space; // RULE_03 RULE_05
	end

	// ----------------------------------------------------------------
	// interrupt outputs
	// ----------------------------------------------------------------
	always_comb begin
		periph_int_req = 1'b0;
		for (int g = 0; g < pifb_pkg::NGRP; g++) begin
			periph_int_req = periph_int_req | (|(view[g] & en_r[g])); // RULE_19
		end
		irq = periph_int_req & ctrl_r[pifb_pkg::GIE_BIT] & ctrl_r[pifb_pkg::PERIPHERAL_INT_ENABLE_BIT];
	end

	// ----------------------------------------------------------------
	// AXI4-Lite handshakes and address decode
	// ----------------------------------------------------------------
	assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~bvalid_r;
	assign s_axi_wready = s_axi_awready;
	assign s_axi_arready = ~rvalid_r;
	assign wr_go = s_axi_awready;
	assign rd_go = s_axi_arvalid & ~rvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;

	// per-group write hit on the flag registers
	always_comb begin
		for (int g = 0; g < pifb_pkg::NGRP; g++) begin
			hit[g] = wr_go & s_axi_wstrb[0] &
				(s_axi_awaddr == pifb_pkg::FLAG_BASE + 6'(4 * g));
		end
	end

	// ----------------------------------------------------------------
	// register next values: set wins over write-one-to-clear
	// ----------------------------------------------------------------
	always_comb begin
		ctrl_nxt = ctrl_r;
		en_nxt = en_r;
		gate_prev_nxt = periph_ev.tmr1_gate_active;
		cwg_prev_nxt = periph_ev.cwg_shutdown;
		for (int g = 0; g < pifb_pkg::NGRP; g++) begin
			flag_nxt[g] = flag_r[g];
			if (hit[g]) begin
				// receive/transmit bits sit outside sticky_mask, so writes miss them
				flag_nxt[g] = flag_nxt[g] & ~(s_axi_wdata[7:0] & sticky_mask[g]); // RULE_02
			end
			flag_nxt[g] = (flag_nxt[g] | set_vec[g]) & sticky_mask[g];
			if (wr_go && s_axi_wstrb[0] && s_axi_awaddr == pifb_pkg::EN_BASE + 6'(4 * g)) begin
				en_nxt[g] = s_axi_wdata[7:0] & mask[g]; // RULE_16
			end
		end
		if (wr_go && s_axi_wstrb[0] && s_axi_awaddr == pifb_pkg::CTRL_OFS) begin
			ctrl_nxt = s_axi_wdata[7:0] & pifb_pkg::MASK_CTRL;
		end
	end

	// flag, enable and control registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int g = 0; g < pifb_pkg::NGRP; g++) begin
				flag_r[g] <= pifb_pkg::RST_VAL; // RULE_17
				en_r[g] <= pifb_pkg::RST_VAL;
			end
			ctrl_r <= pifb_pkg::RST_VAL;
			gate_prev_r <= 1'b0;
			cwg_prev_r <= 1'b0;
		end else begin
			flag_r <= flag_nxt;
			en_r <= en_nxt;
			ctrl_r <= ctrl_nxt;
			gate_prev_r <= gate_prev_nxt;
			cwg_prev_r <= cwg_prev_nxt;
		end
	end

	// ----------------------------------------------------------------
	// bus responses
	// ----------------------------------------------------------------
	always_comb begin
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r;
		rresp_nxt = rresp_r;
		rdata_nxt = rdata_r;
		if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		if (wr_go) begin
			bvalid_nxt = 1'b1;
			bresp_nxt = (s_axi_awaddr < pifb_pkg::MAP_END && s_axi_awaddr[1:0] == 2'h0) ?
				pifb_pkg::RESP_OKAY : pifb_pkg::RESP_SLVERR;
		end
		if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
		if (rd_go) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = pifb_pkg::RESP_SLVERR;
			rdata_nxt = 32'h0000_0000;
			if (s_axi_araddr == pifb_pkg::CTRL_OFS) begin
				rresp_nxt = pifb_pkg::RESP_OKAY;
				rdata_nxt = {24'h00_0000, ctrl_r};
			end
			for (int g = 0; g < pifb_pkg::NGRP; g++) begin
				if (s_axi_araddr == pifb_pkg::EN_BASE + 6'(4 * g)) begin
					rresp_nxt = pifb_pkg::RESP_OKAY;
					rdata_nxt = {24'h00_0000, en_r[g]};
				end
				if (s_axi_araddr == pifb_pkg::FLAG_BASE + 6'(4 * g)) begin
					rresp_nxt = pifb_pkg::RESP_OKAY;
					rdata_nxt = {24'h00_0000, view[g]};
				end
			end
		end
	end

	// response registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r <= pifb_pkg::RESP_OKAY;
			rvalid_r <= 1'b0;
			rresp_r <= pifb_pkg::RESP_OKAY;
			rdata_r <= 32'h0000_0000;
		end else begin
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rresp_r <= rresp_nxt;
			rdata_r <= rdata_nxt;
		end
	end

endmodule

// ==== pifb_flag_bank_monitor.sv ====
// pifb_flag_bank_monitor: concurrent checks on the flag bank ports.
// assumes one clock domain and the register map of pifb_pkg.
`timescale 1ns/1ps
module pifb_flag_bank_monitor #(
	parameter bit HAS_COMP2 = 1'h1 // larger variant present
) (
	input wire logic aclk, // clock
	input wire logic aresetn, // sync reset, low
	input wire logic s_axi_awvalid, // aw valid
	input wire logic s_axi_wvalid, // w valid
	input wire logic s_axi_awready, // aw ready
	input wire logic [1:0] s_axi_bresp, // b response
	input wire logic s_axi_bvalid, // b valid
	input wire logic s_axi_bready, // b ready
	input wire logic [5:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // ar valid
	input wire logic s_axi_arready, // ar ready
	input wire logic [31:0] s_axi_rdata, // read data
	input wire logic [1:0] s_axi_rresp, // r response
	input wire logic s_axi_rvalid, // r valid
	input wire logic s_axi_rready, // r ready
	input wire pifb_pkg::pifb_serial_t serial_st, // buffer levels
	input wire logic periph_int_req, // ungated request
	input wire logic irq // gated request
);
	logic [7:0] mask_r;
	logic [7:0] mask_nxt;
	// implemented-bit mask of the register being read
	always_comb begin
		mask_nxt = mask_r;
		if (s_axi_arvalid && s_axi_arready) begin
			case (s_axi_araddr)
				6'h00: mask_nxt = pifb_pkg::MASK_CTRL;
				6'h04, 6'h1C: mask_nxt = HAS_COMP2 ? pifb_pkg::MASK_COMP2 : 8'h00;
				6'h08, 6'h20: mask_nxt = pifb_pkg::MASK_SERIAL;
				6'h0C, 6'h24: mask_nxt = pifb_pkg::MASK_TIMER;
				6'h10, 6'h28: mask_nxt = pifb_pkg::MASK_LOGIC;
				6'h14, 6'h2C: mask_nxt = pifb_pkg::MASK_CAPT;
				6'h18, 6'h30: mask_nxt = pifb_pkg::MASK_MISC;
				default: mask_nxt = 8'h00;
			endcase
		end
	end
	// register the mask
	always_ff @(posedge aclk) begin
		mask_r <= mask_nxt;
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	AST_B_AFTER_TAKE: assert property (s_axi_awvalid && s_axi_wvalid && s_axi_awready |=> s_axi_bvalid)
		else $error("write response missing after take");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	AST_R_AFTER_TAKE: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read response missing after take");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	AST_R_SLVERR: assert property (s_axi_arvalid && s_axi_arready && (s_axi_araddr >= pifb_pkg::MAP_END
		|| s_axi_araddr[1:0] != 2'h0) |=> s_axi_rresp == pifb_pkg::RESP_SLVERR)
		else $error("bad read address not refused");
	AST_UNIMPL_ZERO: assert property (s_axi_rvalid |-> (s_axi_rdata & ~{24'h0, mask_r}) == 32'h0)
		else $error("unimplemented bit reads one");
	AST_IRQ_GATE: assert property (irq |-> periph_int_req)
		else $error("irq without peripheral request");
	AST_FLAG_STICKY: assert property (periph_int_req && !(s_axi_awvalid && s_axi_wvalid && s_axi_awready)
		##1 serial_st == $past(serial_st) |-> periph_int_req)
		else $error("request fell without a write");
	AST_RST_CLEAR: assert property (@(posedge aclk) disable iff (1'h0)
		!aresetn |=> !periph_int_req && !s_axi_bvalid && !s_axi_rvalid)
		else $error("state not cleared by reset");
	cover property (irq);
	cover property ($fell(periph_int_req));
	cover property (s_axi_rvalid && s_axi_rresp == pifb_pkg::RESP_SLVERR);
endmodule

bind pifb_flag_bank pifb_flag_bank_monitor #(.HAS_COMP2(HAS_COMP2)) u_mon (.*);

// ==== pifb_periph_model.sv ====
// pifb_periph_model: peripherals that raise events and fill serial buffers.
// assumes the bench requests one event pattern at a time.
`timescale 1ns/1ps
module pifb_periph_model #(
	parameter int DEPTH = 2 // serial buffer depth
) (
	input wire logic aclk, // clock
	input wire pifb_pkg::pifb_event_t ev_req, // pattern to issue
	input wire logic ev_go, // issue for one cycle
	input wire logic rx_push, // byte arrives
	input wire logic rx_pop, // data register read
	input wire logic tx_push, // data register written
	input wire logic tx_pop, // shifter takes a byte
	output pifb_pkg::pifb_event_t periph_ev, // event pulses
	output pifb_pkg::pifb_serial_t serial_st // buffer levels
);
	pifb_pkg::pifb_event_t ev_r = '0;
	int rx_n = 0;
	int tx_n = 0;
	// one-cycle events and buffer occupancy
	always @(posedge aclk) begin
		ev_r <= ev_go ? ev_req : '0;
		if (rx_push && rx_n < DEPTH) rx_n <= rx_n + 1;
		if (rx_pop && rx_n > 0) rx_n <= rx_n - 1;
		if (tx_push && tx_n < DEPTH) tx_n <= tx_n + 1;
		if (tx_pop && tx_n > 0) tx_n <= tx_n - 1;
	end
	assign periph_ev = ev_r;
	assign serial_st.rx_not_empty = rx_n != 0;
	assign serial_st.tx_has_space = tx_n < DEPTH;
endmodule

// ==== pifb_flag_bank_tb_top.sv ====
// pifb_flag_bank_tb_top: self-checking bench for the flag bank.
// assumes the design, monitor and peripheral model are compiled first.
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin mismatches++; $display("mismatch %s exp %h got %h", n, e, s); end end
module pifb_flag_bank_tb_top;
	typedef struct packed {
		logic [24:0] ev;
		logic [5:0] a;
		logic [7:0] x;
		logic [7:0] y;
	} pifb_row_t;
	// event pattern, flag address, flag after event, flag after clear
	pifb_row_t rows [18] = '{'{25'h1000000, 6'h20, 8'h12, 8'h10}, '{25'h0800000, 6'h20, 8'h11, 8'h10},
		'{25'h0500000, 6'h24, 8'h02, 8'h00}, '{25'h0400000, 6'h24, 8'h00, 8'h00},
		'{25'h0200000, 6'h24, 8'h02, 8'h00}, '{25'h0300000, 6'h24, 8'h00, 8'h00},
		'{25'h0080000, 6'h24, 8'h01, 8'h00}, '{25'h0040000, 6'h28, 8'h01, 8'h00},
		'{25'h0004000, 6'h28, 8'h10, 8'h00}, '{25'h0020000, 6'h28, 8'h80, 8'h00},
		'{25'h0000300, 6'h2C, 8'h03, 8'h00}, '{25'h00014C0, 6'h2C, 8'h03, 8'h00},
		'{25'h0001700, 6'h2C, 8'h00, 8'h00}, '{25'h0002830, 6'h2C, 8'h03, 8'h00},
		'{25'h0000008, 6'h30, 8'h20, 8'h00}, '{25'h0000004, 6'h30, 8'h10, 8'h00},
		'{25'h0000002, 6'h30, 8'h01, 8'h00}, '{25'h0000001, 6'h1C, 8'h02, 8'h00}};
	logic [7:0] msk [13] = '{8'hC1, 8'h02, 8'h33, 8'h03, 8'hF1, 8'h03, 8'h31, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00};
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [5:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
	logic [3:0] s_axi_wstrb = 4'hF, ser = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, dat;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
	logic s_axi_rready = 1'h0, ev_go = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, periph_int_req, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp, wbr;
	pifb_pkg::pifb_event_t ev_req = '0, periph_ev;
	pifb_pkg::pifb_serial_t serial_st;
	int mismatches = 0, checked = 0;
	// clock and parts
	always #4 aclk = ~aclk;
	pifb_flag_bank uut (.*);
	pifb_periph_model #(.DEPTH(2)) u_periph (.*, .rx_push(ser[0]), .rx_pop(ser[1]), .tx_push(ser[2]), .tx_pop(ser[3]));
	// bus write: address and data together, each released when taken, then response
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic aw_t;
		logic w_t;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		@(negedge aclk);
		while (s_axi_awvalid || s_axi_wvalid) begin
			aw_t = (s_axi_awready === 1'h1);
			w_t = (s_axi_wready === 1'h1);
			@(posedge aclk);
			if (aw_t) s_axi_awvalid <= 1'h0;
			if (w_t) s_axi_wvalid <= 1'h0;
			@(negedge aclk);
		end
		// response ready held back one cycle so the response must stand
		@(posedge aclk);
		s_axi_bready <= 1'h1;
		@(negedge aclk);
		while (s_axi_bvalid !== 1'h1) @(negedge aclk);
		wbr = s_axi_bresp;
		@(posedge aclk);
		s_axi_bready <= 1'h0;
	endtask
	// bus read
	task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		@(negedge aclk);
		while (s_axi_arready !== 1'h1) @(negedge aclk);
		@(posedge aclk);
		s_axi_arvalid <= 1'h0;
		// read ready held back one cycle so the data must stand
		@(posedge aclk);
		s_axi_rready <= 1'h1;
		@(negedge aclk);
		while (s_axi_rvalid !== 1'h1) @(negedge aclk);
		d = s_axi_rdata;
		r = s_axi_rresp;
		@(posedge aclk);
		s_axi_rready <= 1'h0;
	endtask
	// read and compare, ending mid-cycle
	task automatic rc(input logic [5:0] a, input logic [7:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		@(negedge aclk);
		`CHK("read data", {24'h0, e}, d)
		`CHK("read resp", pifb_pkg::RESP_OKAY, r)
	endtask
	// issue one event pattern and let the flag land
	task automatic fire(input logic [24:0] v);
		@(posedge aclk);
		ev_req <= v;
		ev_go <= 1'h1;
		@(posedge aclk);
		ev_go <= 1'h0;
		repeat (3) @(posedge aclk);
	endtask
	// one-cycle serial buffer strobes
	task automatic sp(input logic [3:0] v);
		@(posedge aclk);
		ser <= v;
		@(posedge aclk);
		ser <= '0;
	endtask
	task automatic rst;
		@(posedge aclk);
		aresetn <= 1'h0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'h1;
	endtask
	task summarize;
		if (mismatches == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// main sequence
	initial begin
		rst();
		wr(6'h00, 8'hC0);
		`CHK("write resp", pifb_pkg::RESP_OKAY, wbr)
		foreach (rows[i]) begin
			wr(rows[i].a - 6'h18, rows[i].x ^ rows[i].y);
			fire(rows[i].ev);
			rc(rows[i].a, rows[i].x);
			`CHK("request", rows[i].x != rows[i].y, periph_int_req)
			`CHK("irq", rows[i].x != rows[i].y, irq)
			wr(rows[i].a, 8'hFF);
			rc(rows[i].a, rows[i].y);
			`CHK("request cleared", 1'h0, periph_int_req)
			wr(rows[i].a - 6'h18, 8'h00);
		end
		for (int i = 0; i < 13; i++) begin
			wr(6'(4 * i), 8'hFF);
			rc(6'(4 * i), msk[i]);
			wr(6'(4 * i), 8'h00);
		end
		rd(6'h34, dat, rsp);
		`CHK("unmapped resp", pifb_pkg::RESP_SLVERR, rsp)
		`CHK("unmapped data", 32'h0, dat)
		rd(6'h06, dat, rsp);
		`CHK("unaligned resp", pifb_pkg::RESP_SLVERR, rsp)
		// low byte strobe off: answered but nothing stored
		@(posedge aclk);
		s_axi_wstrb <= 4'hE;
		wr(6'h0C, 8'h03);
		s_axi_wstrb <= 4'hF;
		`CHK("no strobe resp", pifb_pkg::RESP_OKAY, wbr)
		rc(6'h0C, 8'h00);
		wr(6'h34, 8'hFF);
		`CHK("unmapped write resp", pifb_pkg::RESP_SLVERR, wbr)
		sp(4'h1);
		rc(6'h20, 8'h30);
		sp(4'h4);
		sp(4'h4);
		rc(6'h20, 8'h20);
		wr(6'h20, 8'hFF);
		rc(6'h20, 8'h20);
		sp(4'hA);
		rc(6'h20, 8'h10);
		wr(6'h0C, 8'h01);
		// overflow and write-one-to-clear land on one edge: the set must win
		fork
			fire(25'h0080000);
			begin
				@(posedge aclk);
				wr(6'h24, 8'hFF);
			end
		join
		rc(6'h24, 8'h01);
		`CHK("request ungated", 1'h1, periph_int_req)
		`CHK("irq gated off", 1'h0, irq)
		rst();
		rc(6'h24, 8'h00);
		rc(6'h0C, 8'h00);
		summarize();
	end
	// watchdog
	initial begin
		#200000;
		mismatches++;
		summarize();
	end
endmodule
